// file: logic/disp_cmd_regs.svh
// Register offsets, control-word bit positions and reply codes
// of the remote dispense command parser.
// Included by the parser only; definitions only.
`ifndef DISP_CMD_REGS_SVH
`define DISP_CMD_REGS_SVH
`define CW_OFF 0
`define CW_RESET 16'h0000
`define CW_TRIG 0
`define CW_HALT 1
`define CW_DOZE 2
`define CW_LOG0 3
`define CW_CAL 4
`define CW_PARAM 5
`define CW_PROG 6
`define CW_UNIT 7
`define CW_LOG1 11
`define CW_KEEP_MASK 32'h0000F8FF
`define REG_PROG 1
`define REG_MODE 2
`define REG_PUNIT 4
`define REG_VUNIT 6
`define REG_PARAM_LAST 9
`define REG_DATE 10
`define REG_TIME 11
`define MODE_STEADY 32'h00000002
`define CMD_READ 32'h00000003
`define CMD_WRITE 32'h00000010
`define CMD_ERR_BIT 8'h80
`define ERR_FMT 2'h1
`define ERR_LIM 2'h2
`define CH_ZERO 8'h30
`define CH_NINE 8'h39
`define CH_COMMA 8'h2C
`define CH_SEMI 8'h3B
`define CH_MINUS 8'h2D
`define CH_SPACE 8'h20
`endif

// file: logic/disp_cmd_pkg.sv
// Types shared by the remote dispense command parser.
// Assumes nothing of its surroundings.
package disp_cmd_pkg;
  typedef enum logic [3:0] {
    S_RX = 4'b0001,
    S_CONV = 4'b0010,
    S_DIG = 4'b0100,
    S_SEP = 4'b1000
  } phase_t;
endpackage

// file: logic/disp_cmd_parser.sv
// Remote dispense command parser: text requests in, text replies out,
// control word edge/level actions toward the dispenser core.
// Assumes RX/TX byte streams come from logic on MCLK (no synchronisers).
// Functional notes
// - Trigger rising edge starts dispense; falling edge stops it in steady mode.
// - Emergency stop follows the halt flag level.
// - Sleep follows the doze flag level.
// - Log erased only when both log flags become set; one of them may already be set.
// - Clock-set rising edge loads date and time registers into calendar.
// - Parameter-load rising edge adopts registers one to nine.
// - Parameter-load or program-select rising edge adopts program number.
// - Parameter-load or unit-load rising edge adopts pressure and vacuum units.
// - Valid read echoes command, start, count, then values ascending.
// - Every request is parsed and validated before any action.
// - Error reply is command with 0x80 set, then error code.
// - Incomplete frame answers error code -1.
// - Count outside 1 to 20 answers error code -2.
// - Every message ends with a semicolon.
// - Writes use code 16; failed write answers 144.
`timescale 1ns/10ps
`default_nettype none
`include "disp_cmd_regs.svh"
module disp_cmd_parser #(
  parameter int NUM_REGS = 20
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  output logic RX_READY,
  output logic TX_VALID,
  output logic [7:0] TX_DATA,
  input wire logic TX_READY,
  output logic DISPENSE_START,
  output logic DISPENSE_STOP,
  output logic RUNNING,
  output logic HALT,
  output logic DOZE,
  output logic LOG_ERASE,
  output logic CAL_LOAD,
  output logic [31:0] CAL_DATE,
  output logic [31:0] CAL_TIME,
  output logic PARAM_LOAD,
  output logic [4:0] PROGRAM,
  output logic [2:0] DISP_MODE,
  output logic [1:0] PRESS_UNIT,
  output logic [1:0] VAC_UNIT
);
  import disp_cmd_pkg::*;

  if (NUM_REGS < 12 || NUM_REGS > 64) begin : g_chk
    $error("NUM_REGS must lie in 12..64");
  end

  typedef struct packed {
    phase_t ph;
    logic [NUM_REGS-1:0][31:0] stg;
    logic [NUM_REGS-1:0][31:0] act;
    logic [NUM_REGS-1:0][31:0] wbuf;
    logic [15:0] cw_prev;
    logic [31:0] acc;
    logic [31:0] f_cmd;
    logic [31:0] f_start;
    logic [31:0] f_cnt;
    logic [7:0] nf;
    logic dig;
    logic bad;
    logic err;
    logic [1:0] ecode;
    logic [7:0] item;
    logic [7:0] nitems;
    logic [31:0] bin;
    logic [39:0] bcd;
    logic [5:0] step;
    logic [3:0] didx;
    logic nz;
    logic neg_pend;
    logic rx_rdy;
    logic tx_v;
    logic [7:0] tx_d;
    logic run;
    logic start;
    logic stop;
    logic halt;
    logic doze;
    logic log_erase;
    logic cal_load;
    logic param_load;
  } st_t;

  st_t s_q;
  st_t s_d;

  always_comb begin
    logic [15:0] cw;
    logic [15:0] rise;
    logic [15:0] fall;
    logic [31:0] val;
    logic [32:0] span;
    logic lim;
    logic can_tx;
    logic [3:0] d;
    int r;
    cw = 16'h0000;
    rise = 16'h0000;
    fall = 16'h0000;
    val = 32'h0;
    span = 33'h0;
    lim = 1'b0;
    can_tx = 1'b0;
    d = 4'h0;
    r = 0;
    s_d = s_q;
    s_d.start = 1'b0;
    s_d.stop = 1'b0;
    s_d.log_erase = 1'b0;
    s_d.cal_load = 1'b0;
    s_d.param_load = 1'b0;
    if (s_q.tx_v && TX_READY) begin
      s_d.tx_v = 1'b0;
    end
    can_tx = !s_q.tx_v || TX_READY;

    cw = s_q.stg[`CW_OFF][15:0];
    rise = cw & ~s_q.cw_prev;
    fall = ~cw & s_q.cw_prev;
    s_d.cw_prev = cw;
    s_d.halt = cw[`CW_HALT];
    s_d.doze = cw[`CW_DOZE];
    if (rise[`CW_TRIG]) begin
      s_d.run = 1'b1;
      s_d.start = 1'b1;
    end
    if (fall[`CW_TRIG] && s_q.act[`REG_MODE] == `MODE_STEADY) begin
      s_d.run = 1'b0;
      s_d.stop = 1'b1;
    end
    if (cw[`CW_HALT]) begin
      s_d.run = 1'b0;
    end
    s_d.log_erase = cw[`CW_LOG0] && cw[`CW_LOG1]
      && !(s_q.cw_prev[`CW_LOG0] && s_q.cw_prev[`CW_LOG1]);
    if (rise[`CW_CAL]) begin
      s_d.act[`REG_DATE] = s_q.stg[`REG_DATE];
      s_d.act[`REG_TIME] = s_q.stg[`REG_TIME];
      s_d.cal_load = 1'b1;
    end
    if (rise[`CW_PARAM]) begin
      for (int i = 1; i <= `REG_PARAM_LAST; i++) begin
        s_d.act[i] = s_q.stg[i];
      end
      s_d.param_load = 1'b1;
    end
    if (rise[`CW_PARAM] || rise[`CW_PROG]) begin
      s_d.act[`REG_PROG] = s_q.stg[`REG_PROG];
    end
    if (rise[`CW_PARAM] || rise[`CW_UNIT]) begin
      s_d.act[`REG_PUNIT] = s_q.stg[`REG_PUNIT];
      s_d.act[`REG_VUNIT] = s_q.stg[`REG_VUNIT];
    end

    // Reply item value: header fields, error code, or register data
    if (s_q.item == 8'h00) begin
      val = s_q.err ? {24'h0, s_q.f_cmd[7:0] | `CMD_ERR_BIT} : s_q.f_cmd;
    end else if (s_q.item == 8'h01) begin
      val = s_q.err ? {30'h0, s_q.ecode} : s_q.f_start;
    end else if (s_q.item == 8'h02) begin
      val = s_q.f_cnt;
    end else begin
      r = int'(s_q.f_start) + int'(s_q.item) - 3;
      if (s_q.f_cmd == `CMD_WRITE) begin
        val = s_q.wbuf[int'(s_q.item) - 3];
      end else if (r == `CW_OFF) begin
        val = {28'h0, 1'b0, s_q.doze, s_q.halt, s_q.run};
      end else begin
        val = s_q.act[r];
      end
    end

    unique case (s_q.ph)
      S_RX: begin
        if (RX_VALID) begin
          if (RX_DATA >= `CH_ZERO && RX_DATA <= `CH_NINE) begin
            s_d.acc = 32'(s_q.acc * 32'd10) + {28'h0, RX_DATA[3:0]};
            s_d.dig = 1'b1;
          end else if (RX_DATA == `CH_COMMA || RX_DATA == `CH_SEMI) begin
            if (!s_q.dig) begin
              s_d.bad = 1'b1;
            end
            if (s_q.nf == 8'h00) begin
              s_d.f_cmd = s_q.acc;
            end else if (s_q.nf == 8'h01) begin
              s_d.f_start = s_q.acc;
            end else if (s_q.nf == 8'h02) begin
              s_d.f_cnt = s_q.acc;
            end else if (int'(s_q.nf) - 3 < NUM_REGS) begin
              s_d.wbuf[int'(s_q.nf) - 3] = s_q.acc;
            end else begin
              s_d.bad = 1'b1;
            end
            s_d.nf = s_q.nf + 8'h01;
            s_d.acc = 32'h0;
            s_d.dig = 1'b0;
          end else if (RX_DATA != `CH_SPACE) begin
            s_d.bad = 1'b1;
          end
          if (RX_DATA == `CH_SEMI) begin
            span = {1'b0, s_d.f_start} + {1'b0, s_d.f_cnt};
            lim = s_d.f_start >= 32'(NUM_REGS) || s_d.f_cnt == 32'h0
              || s_d.f_cnt > 32'(NUM_REGS) || span > 33'(NUM_REGS);
            s_d.err = 1'b1;
            s_d.ecode = `ERR_FMT;
            if (s_d.bad) begin
              s_d.ecode = `ERR_FMT;
            end else if (s_d.f_cmd == `CMD_READ) begin
              if (s_d.nf != 8'h03) begin
                s_d.ecode = `ERR_FMT;
              end else if (lim) begin
                s_d.ecode = `ERR_LIM;
              end else begin
                s_d.err = 1'b0;
              end
            end else if (s_d.f_cmd == `CMD_WRITE) begin
              if (s_d.nf < 8'h03) begin
                s_d.ecode = `ERR_FMT;
              end else if (lim) begin
                s_d.ecode = `ERR_LIM;
              end else if (32'(s_d.nf) != s_d.f_cnt + 32'd3) begin
                s_d.ecode = `ERR_FMT;
              end else begin
                s_d.err = 1'b0;
                for (int i = 0; i < NUM_REGS; i++) begin
                  if (i < int'(s_d.f_cnt) && int'(s_d.f_start) + i < NUM_REGS) begin
                    s_d.stg[int'(s_d.f_start) + i] = s_d.wbuf[i];
                  end
                end
                s_d.stg[`CW_OFF] = s_d.stg[`CW_OFF] & `CW_KEEP_MASK;
              end
            end
            s_d.nitems = s_d.err ? 8'h02 : 8'(s_d.f_cnt + 32'd3);
            s_d.item = 8'h00;
            s_d.step = 6'h00;
            s_d.nf = 8'h00;
            s_d.bad = 1'b0;
            s_d.rx_rdy = 1'b0;
            s_d.ph = S_CONV;
          end
        end
      end
      S_CONV: begin
        if (s_q.step == 6'h00) begin
          s_d.bin = val;
          s_d.bcd = 40'h0;
        end else begin
          for (int k = 0; k < 10; k++) begin
            if (s_d.bcd[k*4 +: 4] >= 4'h5) begin
              s_d.bcd[k*4 +: 4] = s_d.bcd[k*4 +: 4] + 4'h3;
            end
          end
          {s_d.bcd, s_d.bin} = {s_d.bcd[38:0], s_d.bin, 1'b0};
        end
        s_d.step = s_q.step + 6'h01;
        if (s_q.step == 6'd32) begin
          s_d.didx = 4'd9;
          s_d.nz = 1'b0;
          s_d.neg_pend = s_q.err && s_q.item == 8'h01;
          s_d.ph = S_DIG;
        end
      end
      S_DIG: begin
        d = s_q.bcd[s_q.didx*4 +: 4];
        if (can_tx) begin
          if (s_q.neg_pend) begin
            s_d.neg_pend = 1'b0;
            s_d.tx_v = 1'b1;
            s_d.tx_d = `CH_MINUS;
          end else begin
            if (d != 4'h0 || s_q.nz || s_q.didx == 4'h0) begin
              s_d.tx_v = 1'b1;
              s_d.tx_d = `CH_ZERO | {4'h0, d};
              s_d.nz = 1'b1;
            end
            if (s_q.didx == 4'h0) begin
              s_d.ph = S_SEP;
            end else begin
              s_d.didx = s_q.didx - 4'h1;
            end
          end
        end
      end
      S_SEP: begin
        if (can_tx) begin
          s_d.tx_v = 1'b1;
          if (s_q.item == s_q.nitems - 8'h01) begin
            s_d.tx_d = `CH_SEMI;
            s_d.rx_rdy = 1'b1;
            s_d.ph = S_RX;
          end else begin
            s_d.tx_d = `CH_COMMA;
            s_d.item = s_q.item + 8'h01;
            s_d.step = 6'h00;
            s_d.ph = S_CONV;
          end
        end
      end
      default: begin
        s_d.ph = S_RX;
        s_d.rx_rdy = 1'b1;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= '0;
      s_q.ph <= S_RX;
      s_q.rx_rdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign RX_READY = s_q.rx_rdy;
  assign TX_VALID = s_q.tx_v;
  assign TX_DATA = s_q.tx_d;
  assign DISPENSE_START = s_q.start;
  assign DISPENSE_STOP = s_q.stop;
  assign RUNNING = s_q.run;
  assign HALT = s_q.halt;
  assign DOZE = s_q.doze;
  assign LOG_ERASE = s_q.log_erase;
  assign CAL_LOAD = s_q.cal_load;
  assign CAL_DATE = s_q.act[`REG_DATE];
  assign CAL_TIME = s_q.act[`REG_TIME];
  assign PARAM_LOAD = s_q.param_load;
  assign PROGRAM = s_q.act[`REG_PROG][4:0];
  assign DISP_MODE = s_q.act[`REG_MODE][2:0];
  assign PRESS_UNIT = s_q.act[`REG_PUNIT][1:0];
  assign VAC_UNIT = s_q.act[`REG_VUNIT][1:0];

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  sequence trig_rise_s;
    $rose(s_q.stg[`CW_OFF][`CW_TRIG]);
  endsequence
  sequence prog_edge_s;
    $rose(s_q.stg[`CW_OFF][`CW_PARAM]) or $rose(s_q.stg[`CW_OFF][`CW_PROG]);
  endsequence

  // Halt in the same word suppresses running but not the start pulse
  trig_start_a: assert property (trig_rise_s |=> DISPENSE_START && (RUNNING == !HALT))
    else $error("trigger edge gave no start");
  halt_level_a: assert property (##1 HALT == $past(s_q.stg[`CW_OFF][`CW_HALT]))
    else $error("halt does not follow flag");
  doze_level_a: assert property (##1 DOZE == $past(s_q.stg[`CW_OFF][`CW_DOZE]))
    else $error("doze does not follow flag");
  log_single_a: assert property (!s_q.stg[`CW_OFF][`CW_LOG1] |=> !LOG_ERASE)
    else $error("log erased with one flag");
  cal_hold_a: assert property (!$rose(s_q.stg[`CW_OFF][`CW_CAL]) |=> $stable(CAL_DATE))
    else $error("calendar changed without edge");
  param_hold_a: assert property (
    !$rose(s_q.stg[`CW_OFF][`CW_PARAM]) |=> $stable(s_q.act[3]))
    else $error("parameter changed without edge");
  prog_take_a: assert property (
    prog_edge_s |=> PROGRAM == $past(s_q.stg[`REG_PROG][4:0]))
    else $error("program not adopted");
  unit_take_a: assert property (
    $rose(s_q.stg[`CW_OFF][`CW_UNIT]) |=> PRESS_UNIT == $past(s_q.stg[`REG_PUNIT][1:0]))
    else $error("units not adopted");
  rsv_bits_a: assert property (s_q.stg[`CW_OFF][10:8] == 3'h0)
    else $error("reserved control bits stored");
  err_len_a: assert property (
    s_q.ph == S_CONV && s_q.err |-> s_q.nitems == 8'h02)
    else $error("error reply not two fields");
endmodule // disp_cmd_parser
`default_nettype wire

// file: test/client_model.sv
// Client model: sends text requests byte by byte and collects text replies.
// Assumes one request in flight; the bench calls send, then recv.
`timescale 1ns/10ps
`default_nettype none
module client_model (
  input wire logic MCLK,
  input wire logic RX_READY,
  input wire logic TX_VALID,
  input wire logic [7:0] TX_DATA,
  input wire logic SLOW,
  output logic RX_VALID,
  output logic [7:0] RX_DATA,
  output logic TX_READY
);
  int seed = 54;
  initial begin
    RX_VALID = 1'b0;
    RX_DATA = 8'hA5;
    TX_READY = 1'b1;
  end
  // Sink stalls only when the bench asks for it
  always @(posedge MCLK) begin
    TX_READY <= !SLOW || ($random(seed) % 3 != 0);
  end
  task automatic send(input string s);
    @(posedge MCLK);
    for (int i = 0; i < s.len(); i++) begin
      RX_VALID <= 1'b1;
      RX_DATA <= s[i];
      do @(posedge MCLK); while (RX_READY !== 1'b1);
    end
    RX_VALID <= 1'b0;
    // Idle bus shows junk, not the last byte
    RX_DATA <= ~s[s.len()-1];
  endtask
  task automatic recv(output string r);
    r = "";
    for (int k = 0; k < 8000; k++) begin
      @(posedge MCLK);
      if (TX_VALID === 1'b1 && TX_READY) begin
        r = $sformatf("%s%c", r, TX_DATA);
        if (TX_DATA === 8'h3B) break;
      end
    end
  endtask
endmodule // client_model
`default_nettype wire

// file: test/test_remote_dispense_command_parser.sv
// Self-checking bench for the remote dispense command parser.
// Assumes client_model drives the request stream and sinks replies.
`timescale 1ns/10ps
`default_nettype none
module test_remote_dispense_command_parser;
  import disp_cmd_pkg::*;
  logic MCLK, RST_N, SLOW, rx_valid, rx_ready, tx_valid, tx_ready;
  logic [7:0] rx_data, tx_data;
  logic start_p, stop_p, run, halt, doze, erase_p, cal_p, param_p;
  logic [31:0] cal_date, cal_time;
  logic [4:0] prog;
  logic [2:0] mode;
  logic [1:0] pu, vu;
  int err_count, n_checks, n_start, n_stop, n_param, n_erase, n_cal, s, n;
  int seed = 54;
  int act [20];
  string bad [9] = '{"3,0;", "3,0,21;", "3,0,0;", "3,19,2;", "3,a,1;", "16,0,5,0,1,1;",
    "16,0,1,1,5;", "7,1,1;", "16,20,1,0;"};
  string bad_exp [9] = '{"131,-1;", "131,-2;", "131,-2;", "131,-2;", "131,-1;", "144,-1;",
    "144,-1;", "135,-1;", "144,-2;"};
  disp_cmd_parser uut (.MCLK(MCLK), .RST_N(RST_N), .RX_VALID(rx_valid), .RX_DATA(rx_data),
    .RX_READY(rx_ready), .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_READY(tx_ready),
    .DISPENSE_START(start_p), .DISPENSE_STOP(stop_p), .RUNNING(run), .HALT(halt),
    .DOZE(doze), .LOG_ERASE(erase_p), .CAL_LOAD(cal_p), .CAL_DATE(cal_date),
    .CAL_TIME(cal_time), .PARAM_LOAD(param_p), .PROGRAM(prog), .DISP_MODE(mode),
    .PRESS_UNIT(pu), .VAC_UNIT(vu));
  client_model cl (.MCLK(MCLK), .RX_READY(rx_ready), .TX_VALID(tx_valid), .TX_DATA(tx_data),
    .SLOW(SLOW), .RX_VALID(rx_valid), .RX_DATA(rx_data), .TX_READY(tx_ready));
  // Pulses are counted so checks need not hit the exact cycle
  always @(posedge MCLK) begin
    n_start += (start_p === 1'b1);
    n_stop += (stop_p === 1'b1);
    n_param += (param_p === 1'b1);
    n_erase += (erase_p === 1'b1);
    n_cal += (cal_p === 1'b1);
  end
  function automatic string d(input logic [31:0] v);
    return $sformatf("%0d", v);
  endfunction
  function automatic string st();
    return $sformatf("%0d%0d%0d%0d%0d%b%b%b", n_start, n_stop, n_param, n_erase, n_cal,
      run, halt, doze);
  endfunction
  function automatic string rd_exp(input int s, input int n);
    string r;
    if (s > 19 || n < 1 || n > 20 || s + n > 20) return "131,-2;";
    r = $sformatf("3,%0d,%0d", s, n);
    for (int i = s; i < s + n; i++) r = $sformatf("%s,%0d", r, act[i]);
    return {r, ";"};
  endfunction
  task automatic check(input string what, input string seen, input string exp);
    n_checks++;
    if (seen != exp) begin
      err_count++;
      $display("wrong value %s expected %s seen %s", what, exp, seen);
    end
  endtask
  task automatic xfer(input string req, input string exp);
    string r;
    cl.send(req);
    cl.recv(r);
    check(req, r, exp);
  endtask
  task automatic wr(input string req);
    xfer(req, req);
  endtask
  task automatic wrap_up();
    if (err_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    MCLK = 1'b0;
    forever #2.5 MCLK = ~MCLK;
  end
  initial begin
    #(5.0 * 90000);
    err_count++;
    wrap_up();
  end
  initial begin
    RST_N = 1'b0;
    SLOW = 1'b0;
    repeat (16) @(posedge MCLK);
    check("rx_ready", d(rx_ready), "1");
    check("program", d(prog), "0");
    RST_N <= 1'b1;
    xfer("3,1,2;", rd_exp(1, 2));
    wr("16,1,9,5,2,0,1,0,2,0,0,0;");
    check("program", d(prog), "0");
    wr("16,0,1,64;");
    check("program", d(prog), "5");
    check("mode units", d({mode, pu, vu}), "0");
    wr("16,0,1,128;");
    check("units", d({pu, vu}), "6");
    wr("16,0,1,32;");
    check("mode", d(mode), "2");
    act[1] = 5;
    act[2] = 2;
    act[4] = 1;
    act[6] = 2;
    wr("16,0,1,33;");
    check("state", st(), "10100100");
    xfer("3,0,1;", "3,0,1,1;");
    wr("16,0,1,32;");
    check("state", st(), "11100000");
    wr("16,0,1,6;");
    check("state", st(), "11100011");
    act[0] = 6;
    xfer("3,0,2;", rd_exp(0, 2));
    act[0] = 0;
    wr("16,0,1,0;");
    check("state", st(), "11100000");
    wr("16,0,1,8;");
    check("state", st(), "11100000");
    wr("16,0,1,2056;");
    check("state", st(), "11110000");
    wr("16,0,1,1792;");
    check("state", st(), "11110000");
    wr("16,10,2,20210608,114501;");
    check("date", d(cal_date), "0");
    wr("16,0,1,16;");
    check("date time", {d(cal_date), d(cal_time)}, "20210608114501");
    act[10] = 20210608;
    act[11] = 114501;
    foreach (bad[i]) xfer(bad[i], bad_exp[i]);
    check("state", st(), "11111000");
    xfer("3, 4, 1;", rd_exp(4, 1));
    // Trigger fall outside steady mode keeps running
    wr("16,2,1,1;");
    wr("16,0,1,32;");
    check("mode", d(mode), "1");
    wr("16,0,1,1;");
    wr("16,0,1,0;");
    check("state", st(), "21211100");
    wr("16,0,1,2;");
    check("state", st(), "21211010");
    wr("16,0,1,0;");
    check("state", st(), "21211000");
    act[2] = 1;
    SLOW <= 1'b1;
    // Reads judged whole, with sink stalls
    repeat (30) begin
      s = $unsigned($random(seed)) % 21;
      n = $unsigned($random(seed)) % 22;
      xfer($sformatf("3,%0d,%0d;", s, n), rd_exp(s, n));
    end
    wrap_up();
  end
endmodule // test_remote_dispense_command_parser
`default_nettype wire
